// *** rtl/asrwi_ctrl.v ***
// host controller driving an asynchronous 1M x 16 static memory
`timescale 1ns/100ps
`include "asrwi_defs.vh"
// How it works
// R01 - write: select low, select high, strobe low
// R02 - read: selects on, strobe high, gate low
// R03 - memory floats data when deselected or writing
// R04 - write ends when any enable drops
// R05 - data held from setup through write end
// R06 - address stable before and after write
// R07 - strobe may fall with address valid
// R08 - byte selects held through whole write
// R09 - memory drives again after strobe rises
// R10 - strobe width covers setup plus float
// R11 - gate high during write keeps bus floating
// R12 - joint select release keeps outputs floating
// R13 - read waits full access time
// R14 - old data held briefly after address change
// R15 - gate low gives data within gate delay
// R16 - idle by releasing both chip selects
// R17 - deselect before retention, zero delay
// R18 - minimums rounded up to whole cycles
module asrwi_ctrl (
    // clock and reset
    input wire I_CLK,
    input wire I_RST_N,
    // user request
    input wire I_REQ,
    input wire I_WRITE,
    input wire [19:0] I_ADDR,
    input wire [15:0] I_WDATA,
    input wire [1:0] I_BYTE_EN,
    input wire I_RETAIN,
    output wire O_READY,
    output reg O_RVALID,
    output reg [15:0] O_RDATA,
    output reg O_RETAIN_OK,
    // memory pins
    output reg [19:0] O_ADDR,
    output reg O_CHIP_SELECT_ACTIVE_LOW_N,
    output reg O_CHIP_SELECT_ACTIVE_HIGH,
    output reg O_WRITE_STROBE_N,
    output reg O_OUTPUT_GATE_N,
    output reg O_UPPER_BYTE_SELECT_N,
    output reg O_LOWER_BYTE_SELECT_N,
    input wire [15:0] I_DQ,
    output reg [15:0] O_DQ,
    output reg O_DQ_OE
);
    localparam ST_IDLE = 3'h0;
    localparam ST_READ = 3'h1;
    localparam ST_WRITE = 3'h2;
    localparam ST_WREC = 3'h3;
    localparam ST_TURN = 3'h4;

    localparam integer RD_CYC = `ASRWI_RD_CYC;
    localparam integer WE_CYC = `ASRWI_WE_CYC;
    localparam integer REC_CYC = `ASRWI_WR_CYC - `ASRWI_WE_CYC;
    localparam integer TURN_CYC = `ASRWI_TURN_CYC;
    // every count fits the 4-bit timer, so cut to its width on purpose
    localparam [3:0] RD_CNT = RD_CYC[3:0];
    localparam [3:0] WE_CNT = WE_CYC[3:0];
    localparam [3:0] REC_CNT = REC_CYC[3:0];
    localparam [3:0] TURN_CNT = TURN_CYC[3:0];

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg load;
    reg [3:0] load_cnt;
    wire done;

    asrwi_timer u_timer (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .i_load(load),
        .i_count(load_cnt),
        .o_done(done)
    );

    // retention only granted while idle and deselected
    assign O_READY = (state_r == ST_IDLE) && !I_RETAIN;

    always @* begin
        state_nxt = state_r;
        load = 1'b0;
        load_cnt = 4'h0;
        case (state_r)
            ST_IDLE: begin
                if (I_REQ && O_READY && (I_BYTE_EN != 2'h0)) begin
                    load = 1'b1;
                    // R18 round up
                    load_cnt = I_WRITE ? WE_CNT : RD_CNT;
                    state_nxt = I_WRITE ? ST_WRITE : ST_READ;
                end
            end
            ST_READ: begin
                if (done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (done) begin
                    load = 1'b1;
                    load_cnt = REC_CNT;
                    state_nxt = ST_WREC;
                end
            end
            ST_WREC: begin
                if (done) begin
                    load = 1'b1;
                    load_cnt = TURN_CNT;
                    state_nxt = ST_TURN;
                end
            end
            ST_TURN: begin
                if (done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_r <= ST_IDLE;
            O_ADDR <= 20'h00000;
            O_CHIP_SELECT_ACTIVE_LOW_N <= 1'b1;
            O_CHIP_SELECT_ACTIVE_HIGH <= 1'b0;
            O_WRITE_STROBE_N <= 1'b1;
            O_OUTPUT_GATE_N <= 1'b1;
            O_UPPER_BYTE_SELECT_N <= 1'b1;
            O_LOWER_BYTE_SELECT_N <= 1'b1;
            O_DQ <= 16'h0000;
            O_DQ_OE <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 16'h0000;
            O_RETAIN_OK <= 1'b0;
        end else begin
            state_r <= state_nxt;
            O_RVALID <= 1'b0;
            // R17 deselected while idle
            O_RETAIN_OK <= I_RETAIN && (state_r == ST_IDLE);
            case (state_r)
                ST_IDLE: begin
                    if (state_nxt == ST_READ) begin
                        // R02 read enables
                        O_ADDR <= I_ADDR;
                        O_CHIP_SELECT_ACTIVE_LOW_N <= 1'b0;
                        O_CHIP_SELECT_ACTIVE_HIGH <= 1'b1;
                        O_OUTPUT_GATE_N <= 1'b0;
                        O_UPPER_BYTE_SELECT_N <= ~I_BYTE_EN[1];
                        O_LOWER_BYTE_SELECT_N <= ~I_BYTE_EN[0];
                    end else if (state_nxt == ST_WRITE) begin
                        // R01 R07 address, data and strobe together
                        O_ADDR <= I_ADDR;
                        O_DQ <= I_WDATA;
                        O_DQ_OE <= 1'b1;
                        O_CHIP_SELECT_ACTIVE_LOW_N <= 1'b0;
                        O_CHIP_SELECT_ACTIVE_HIGH <= 1'b1;
                        O_WRITE_STROBE_N <= 1'b0;
                        // R11 gate high keeps memory floating
                        O_OUTPUT_GATE_N <= 1'b1;
                        O_UPPER_BYTE_SELECT_N <= ~I_BYTE_EN[1];
                        O_LOWER_BYTE_SELECT_N <= ~I_BYTE_EN[0];
                    end
                end
                ST_READ: begin
                    // R13 R15 sample after full access time
                    if (done) begin
                        O_RVALID <= 1'b1;
                        O_RDATA <= I_DQ;
                        // R16 idle by releasing both selects
                        O_CHIP_SELECT_ACTIVE_LOW_N <= 1'b1;
                        O_CHIP_SELECT_ACTIVE_HIGH <= 1'b0;
                        O_OUTPUT_GATE_N <= 1'b1;
                        O_UPPER_BYTE_SELECT_N <= 1'b1;
                        O_LOWER_BYTE_SELECT_N <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    // R04 R10 strobe rise ends the write
                    if (done) begin
                        O_WRITE_STROBE_N <= 1'b1;
                    end
                end
                ST_WREC: begin
                    // R05 R06 R08 data, address, bytes held past end
                    if (done) begin
                        O_DQ_OE <= 1'b0;
                        O_CHIP_SELECT_ACTIVE_LOW_N <= 1'b1;
                        O_CHIP_SELECT_ACTIVE_HIGH <= 1'b0;
                        O_UPPER_BYTE_SELECT_N <= 1'b1;
                        O_LOWER_BYTE_SELECT_N <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// *** rtl/asrwi_defs.vh ***
// timing constants and widths for the static memory host controller
`ifndef ASRWI_DEFS_VH
`define ASRWI_DEFS_VH

`define ASRWI_CLK_PS 8000
`define ASRWI_AW 20
`define ASRWI_DW 16
// speed grade in ns: 45 or 55
`define ASRWI_GRADE_NS 55
// timing figures in ns for the slower grade
`define ASRWI_READ_CYCLE_MIN_NS 55
`define ASRWI_ADDR_ACCESS_DELAY_NS 55
`define ASRWI_OUTPUT_GATE_TO_DATA_DELAY_NS 25
`define ASRWI_DATA_HOLD_AFTER_ADDRESS_CHANGE_NS 10
`define ASRWI_WRITE_CYCLE_MIN_NS 55
`define ASRWI_WRITE_STROBE_MIN_WIDTH_NS 40
`define ASRWI_ADDRESS_SETUP_TO_WRITE_END_NS 40
`define ASRWI_BYTE_SELECT_TO_WRITE_END_NS 40
`define ASRWI_DATA_SETUP_TO_WRITE_END_NS 25
`define ASRWI_WRITE_TO_FLOAT_NS 20
`define ASRWI_ADDRESS_SETUP_BEFORE_WRITE_NS 0
`define ASRWI_ADDRESS_HOLD_AFTER_WRITE_NS 0
`define ASRWI_DATA_HOLD_AFTER_WRITE_END_NS 0
`define ASRWI_WRITE_RECOVERY_TO_DRIVE_NS 10
// ns to cycles, rounding up
`define ASRWI_CYC(ns) (((ns) * 1000 + `ASRWI_CLK_PS - 1) / `ASRWI_CLK_PS)
`define ASRWI_RD_CYC `ASRWI_CYC(`ASRWI_ADDR_ACCESS_DELAY_NS)
`define ASRWI_WE_CYC `ASRWI_CYC(`ASRWI_DATA_SETUP_TO_WRITE_END_NS + \
    `ASRWI_WRITE_TO_FLOAT_NS)
`define ASRWI_WR_CYC `ASRWI_CYC(`ASRWI_WRITE_CYCLE_MIN_NS)
`define ASRWI_TURN_CYC `ASRWI_CYC(`ASRWI_WRITE_TO_FLOAT_NS)
`define ASRWI_CW 4

`endif

// *** rtl/asrwi_timer.v ***
// down counter that pulses done when a loaded interval expires
`timescale 1ns/100ps
module asrwi_timer (
    // clock and reset
    input wire I_CLK,
    input wire I_RST_N,
    // control
    input wire i_load,
    input wire [3:0] i_count,
    output wire o_done
);
    reg [3:0] cnt_r;
    reg run_r;

    assign o_done = run_r && (cnt_r == 4'h1);

    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            cnt_r <= 4'h0;
            run_r <= 1'b0;
        end else if (i_load) begin
            cnt_r <= i_count;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
                run_r <= 1'b0;
            end
        end
    end
endmodule

// *** sim/asrwi_props.sv ***
// assertions on the memory pins driven by the host controller
`timescale 1ns/100ps
module asrwi_props (
    // clock and reset
    input wire I_CLK,
    input wire I_RST_N,
    // watched ports
    input wire O_READY, input wire O_RVALID, input wire O_RETAIN_OK,
    input wire [19:0] O_ADDR, input wire [15:0] O_DQ, input wire O_DQ_OE,
    input wire O_CHIP_SELECT_ACTIVE_LOW_N, input wire O_WRITE_STROBE_N,
    input wire O_CHIP_SELECT_ACTIVE_HIGH, input wire O_OUTPUT_GATE_N,
    input wire O_UPPER_BYTE_SELECT_N, input wire O_LOWER_BYTE_SELECT_N
);
    wire wr = !O_WRITE_STROBE_N;
    wire oe = !O_OUTPUT_GATE_N;
    wire [1:0] bs = {O_UPPER_BYTE_SELECT_N, O_LOWER_BYTE_SELECT_N};
    wire sel = !O_CHIP_SELECT_ACTIVE_LOW_N && O_CHIP_SELECT_ACTIVE_HIGH;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    a_write_all_on: assert property (wr |-> sel && bs != 2'b11)
        else $error("strobe low without selects");
    a_write_held: assert property (wr && $past(wr) |->
        $stable({O_ADDR, O_DQ, bs})) else $error("write inputs moved");
    a_hold_at_end: assert property ($rose(O_WRITE_STROBE_N) |->
        O_DQ_OE && $stable({O_ADDR, O_DQ})) else $error("no hold at end");
    a_strobe_width: assert property ($fell(O_WRITE_STROBE_N) |->
        wr [*6] ##1 !wr) else $error("strobe width wrong");
    a_gate_off_wr: assert property (wr |-> !oe && O_DQ_OE)
        else $error("gate low in write");
    a_read_len: assert property ($fell(O_OUTPUT_GATE_N) |->
        oe [*7] ##1 (O_RVALID && !oe)) else $error("read length wrong");
    a_no_fight: assert property (oe |-> !O_DQ_OE)
        else $error("both sides drive data");
    a_retain_off: assert property (O_RETAIN_OK |-> !sel && !oe)
        else $error("retention while selected");
    a_turnaround: assert property ($rose(O_WRITE_STROBE_N) |->
        !O_READY [*3]) else $error("turnaround too short");
    c_read: cover property (O_RVALID);
    c_write: cover property ($fell(O_WRITE_STROBE_N));
    c_retain: cover property (O_RETAIN_OK);
endmodule
bind asrwi_ctrl asrwi_props u_props (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .O_READY(O_READY), .O_RVALID(O_RVALID), .O_RETAIN_OK(O_RETAIN_OK),
    .O_ADDR(O_ADDR), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE),
    .O_CHIP_SELECT_ACTIVE_LOW_N(O_CHIP_SELECT_ACTIVE_LOW_N),
    .O_CHIP_SELECT_ACTIVE_HIGH(O_CHIP_SELECT_ACTIVE_HIGH),
    .O_WRITE_STROBE_N(O_WRITE_STROBE_N), .O_OUTPUT_GATE_N(O_OUTPUT_GATE_N),
    .O_UPPER_BYTE_SELECT_N(O_UPPER_BYTE_SELECT_N),
    .O_LOWER_BYTE_SELECT_N(O_LOWER_BYTE_SELECT_N));

// *** sim/asrwi_mem.sv ***
// behavioural static memory on the far side of the controller
`timescale 1ns/100ps
module asrwi_mem (
    input wire clk, input wire [19:0] a, input wire cs_n, input wire cs_h,
    input wire we_n, input wire oe_n, input wire ub_n, input wire lb_n,
    input wire [15:0] d,
    output reg [15:0] q
);
    logic [15:0] mem [0:1048575];
    logic [15:0] w, r;
    logic [15:0] r_old = 16'h0000;
    realtime t0 = 0;
    logic tog = 0;
    integer k;
    wire sel = !cs_n && cs_h;
    // drives again as soon as the strobe is high
    wire drv = sel && we_n && !oe_n;
    initial for (k = 0; k < 1048576; k++) mem[k] = 16'h0000;
    // remember what was shown when the access changed
    always @(a or oe_n or sel) begin
        r_old = r;
        t0 = $realtime;
    end
    // lanes stored only while all enables overlap
    always @(posedge clk) begin
        tog <= !tog;
        if (sel && !we_n && !(ub_n && lb_n)) begin
            w = mem[a];
            if (!ub_n) w[15:8] = d[15:8];
            if (!lb_n) w[7:0] = d[7:0];
            mem[a] = w;
        end
    end
    // only selected lanes driven in a read
    // data is inverted from 10 ns until the access time is over: no early luck
    // old word held briefly, then junk until access time is over
    always #1 begin
        r = mem[a];
        if ($realtime - t0 < 10.0) r = r_old;
        else if ($realtime - t0 < 55.0) r = ~r;
        q[15:8] = (drv && !ub_n) ? r[15:8] : {4{tog, !tog}};
        q[7:0] = (drv && !lb_n) ? r[7:0] : {4{!tog, tog}};
    end
endmodule

// *** sim/tb.sv ***
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
module tb;
    reg I_CLK = 0, I_RST_N = 0, I_REQ = 0, I_WRITE = 0, I_RETAIN = 0;
    reg [19:0] I_ADDR = 0;
    reg [15:0] I_WDATA = 0, rd = 0;
    reg [1:0] I_BYTE_EN = 0;
    wire O_READY, O_RVALID, O_RETAIN_OK, O_DQ_OE;
    wire cs_n, cs_h, we_n, oe_n, ub_n, lb_n;
    wire [15:0] O_RDATA, O_DQ, mq;
    wire [19:0] O_ADDR;
    wire [15:0] dq = O_DQ_OE ? O_DQ : mq;
    integer fail_count = 0, total_checks = 0, wr_cnt = 0, i, n;
    reg [53:0] rows [0:3];
    always #4 I_CLK = !I_CLK;
    always @(negedge we_n) wr_cnt++;
    asrwi_ctrl u_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ(I_REQ),
        .I_WRITE(I_WRITE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_BYTE_EN(I_BYTE_EN), .I_RETAIN(I_RETAIN), .O_READY(O_READY),
        .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .O_RETAIN_OK(O_RETAIN_OK),
        .O_ADDR(O_ADDR), .O_CHIP_SELECT_ACTIVE_LOW_N(cs_n),
        .O_CHIP_SELECT_ACTIVE_HIGH(cs_h), .O_WRITE_STROBE_N(we_n),
        .O_OUTPUT_GATE_N(oe_n), .O_UPPER_BYTE_SELECT_N(ub_n),
        .O_LOWER_BYTE_SELECT_N(lb_n), .I_DQ(dq), .O_DQ(O_DQ),
        .O_DQ_OE(O_DQ_OE));
    asrwi_mem u_mem (.clk(I_CLK), .a(O_ADDR), .cs_n(cs_n), .cs_h(cs_h),
        .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .d(dq), .q(mq));
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input [19:0] seen, input [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // request held from a falling edge until the taking rising edge
    task go(input w, input [19:0] a, input [15:0] d, input [1:0] be);
        I_REQ = 1;
        I_WRITE = w;
        I_ADDR = a;
        I_WDATA = d;
        I_BYTE_EN = be;
        // stale data from an earlier read must not pass for fresh
        rd = 16'hxxxx;
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_READY !== 1'b1 && n < 20);
        // a controller that never turns ready is a hang, not a pass
        if (O_READY !== 1'b1) begin
            fail_count++;
            print_verdict;
        end
        @(negedge I_CLK);
        I_REQ = 0;
        do begin
            @(negedge I_CLK);
            n++;
            if (O_RVALID === 1'b1) rd = O_RDATA;
        end while (O_READY !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count++;
            print_verdict;
        end
    endtask
    initial begin
        rows[0] = {20'h00000, 16'h1234, 2'b11, 16'hff34};
        rows[1] = {20'hfffff, 16'habcd, 2'b11, 16'hab99};
        rows[2] = {20'h00000, 16'hff00, 2'b10, 16'hff34};
        rows[3] = {20'hfffff, 16'h0099, 2'b01, 16'hab99};
        repeat (6) @(negedge I_CLK);
        chk({cs_n, cs_h, we_n, oe_n, ub_n, lb_n, O_DQ_OE}, 7'h5e);
        I_RST_N = 1;
        $display("reset test done");
        for (i = 0; i < 4; i++) go(1, rows[i][53:34], rows[i][33:18],
            rows[i][17:16]);
        chk(wr_cnt, 4);
        for (i = 0; i < 4; i++) begin
            go(0, rows[i][53:34], 16'h0, 2'b11);
            chk(rd, rows[i][15:0]);
        end
        $display("row tests done");
        go(0, 20'h00000, 16'h0, 2'b01);
        chk(rd[7:0], 8'h34);
        go(1, 20'h00005, 16'h5555, 2'b00);
        chk({wr_cnt[3:0], O_READY}, 5'h09);
        I_RETAIN = 1;
        repeat (2) @(negedge I_CLK);
        chk({O_RETAIN_OK, O_READY, cs_n, cs_h}, 4'ha);
        I_RETAIN = 0;
        $display("edge tests done");
        print_verdict;
    end
endmodule
